// >>> verilog/lcf_top.sv
// Lock current limit fault handler with Wishbone registers and bridge drive control.
`timescale 1ns/100ps
module lcf_top
  import lcf_pkg::*;
#(
  parameter int RDLY_UNIT_CYC = RDLY_UNIT_US * CLK_MHZ,
  parameter int FILT_SCALE    = CLK_MHZ
)
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        overLimit,
  input  wire logic [31:0] wbAdr,
  input  wire logic [31:0] wbDatIn,
  input  wire logic [3:0]  wbSel,
  input  wire logic        wbWe,
  input  wire logic        wbCyc,
  input  wire logic        wbStb,
  output logic [31:0]      wbDatOut,
  output logic             wbAck,
  output logic             wbErr,
  output logic [1:0]       bridgeDrive,
  output logic             fault_out_n,
  output logic             irq
);

  localparam int CW = 32;

  typedef struct packed
  {
    lcf_cfg_t      cfg;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    lcf_state_t    state;
    logic [31:0]   rtimer;
    logic [3:0]    retries;
    logic [1:0]    drive;
    logic          faultN;
    logic          irq;
    logic [31:0]   rdata;
    logic          ack;
    logic          err;
  } lcf_top_st_t;

  lcf_top_st_t st;
  lcf_top_st_t next_st;

  logic          levelSync;
  logic          lockHit;
  logic [CW-1:0] filtTarget;

  // Decode of a filter code into a cycle count; the zero code passes in one cycle.
  function automatic logic [CW-1:0] filt_cycles(input logic [3:0] code);
    int c;
    c = FILT_US[code] * FILT_SCALE;
    filt_cycles = (code == 4'h0) ? '0 : CW'(c - 1);
  endfunction

  lcf_sync u_sync
  (
    .clk  (clk),
    .nrst (nrst),
    .din  (overLimit),
    .dout (levelSync)
  );

  assign filtTarget = filt_cycles(st.cfg.filt);

  lcf_filter #(.CW(CW)) u_filter
  (
    .clk    (clk),
    .nrst   (nrst),
    .level  (levelSync && st.cfg.mode != LCF_MODE_OFF),
    .target (filtTarget),
    .hit    (lockHit)
  );

  logic        isRetry;
  logic [31:0] rdlyCyc;
  logic        acc;
  logic [3:0]  ofs;
  logic [EV_W-1:0] ev;

  assign isRetry = st.cfg.mode inside {LCF_MODE_RETRY_TRI, LCF_MODE_RETRY_LOW,
                                       LCF_MODE_RETRY_HIGH};
  assign rdlyCyc = 32'((int'(st.cfg.rdly) + 1) * RDLY_UNIT_CYC);
  assign acc     = wbCyc && wbStb && !st.ack && !st.err;
  assign ofs     = wbAdr[3:0];

  always_comb
  begin
    next_st = st;
    ev = '0;
    next_st.ack = 1'b0;
    next_st.err = 1'b0;

    // Fault state machine.
    unique case (st.state)
      LCF_ST_IDLE:
      begin
        next_st.drive  = LCF_DRIVE_RUN;
        next_st.faultN = 1'b1;
        if (lockHit)
        begin
          ev[EV_LOCK] = 1'b1;
          next_st.faultN = 1'b0;
          if (st.cfg.mode == LCF_MODE_REPORT)
            next_st.drive = LCF_DRIVE_RUN;
          else if (isRetry && st.retries < st.cfg.rcnt)
          begin
            next_st.state   = LCF_ST_WAIT;
            next_st.drive   = lcf_brake(st.cfg.mode);
            next_st.rtimer  = '0;
            next_st.retries = st.retries + 4'h1;
          end
          else
          begin
            next_st.state = LCF_ST_LATCH;
            next_st.drive = isRetry && st.cfg.mode == LCF_MODE_RETRY_LOW ?
                            LCF_DRIVE_LOW :
                            lcf_brake(st.cfg.mode);
            ev[EV_LATCH]  = 1'b1;
          end
        end
      end
      LCF_ST_WAIT:
      begin
        if (st.rtimer + 32'h1 >= rdlyCyc)
        begin
          next_st.state  = LCF_ST_IDLE;
          next_st.drive  = LCF_DRIVE_RUN;
          next_st.faultN = 1'b1;
          ev[EV_RETRY]   = 1'b1;
        end
        else
          next_st.rtimer = st.rtimer + 32'h1;
      end
      LCF_ST_LATCH:
      begin
        next_st.faultN = 1'b0;
      end
      default:
        next_st.state = LCF_ST_IDLE;
    endcase

    // Register access.
    if (acc)
    begin
      next_st.ack = 1'b1;
      unique case (ofs)
        OFS_CONFIG:
        begin
          next_st.rdata = 32'h0;
          next_st.rdata[MODE_LSB +: 3] = st.cfg.mode;
          next_st.rdata[FILT_LSB +: 4] = st.cfg.filt;
          next_st.rdata[RDLY_LSB +: 4] = st.cfg.rdly;
          next_st.rdata[RCNT_LSB +: 4] = st.cfg.rcnt;
          if (wbWe)
          begin
            if (wbSel[2] && wbSel[1])
              next_st.cfg.mode = wbDatIn[MODE_LSB +: 3];
            if (wbSel[1])
              next_st.cfg.filt = wbDatIn[FILT_LSB +: 4];
            if (wbSel[0])
            begin
              next_st.cfg.rdly = wbDatIn[RDLY_LSB +: 4];
              next_st.cfg.rcnt = wbDatIn[RCNT_LSB +: 4];
            end
          end
        end
        OFS_STATUS:
        begin
          next_st.rdata = {29'h0, st.status};
          if (wbWe && wbSel[0])
          begin
            next_st.status = st.status & ~wbDatIn[EV_W-1:0];
            // A write of one to the latch bit releases a latched fault.
            if (wbDatIn[EV_LATCH] && st.state == LCF_ST_LATCH)
            begin
              next_st.state   = LCF_ST_IDLE;
              next_st.retries = 4'h0;
              next_st.drive   = LCF_DRIVE_RUN;
              next_st.faultN  = 1'b1;
            end
          end
        end
        OFS_MASK:
        begin
          next_st.rdata = {29'h0, st.mask};
          if (wbWe && wbSel[0])
            next_st.mask = wbDatIn[EV_W-1:0];
        end
        OFS_STATE:
        begin
          next_st.rdata = {24'h0, st.retries, st.faultN, st.drive, st.state[1]};
        end
        default:
        begin
          next_st.ack   = 1'b0;
          next_st.err   = 1'b1;
          next_st.rdata = 32'h0;
        end
      endcase
    end

    // Events win over a same-cycle clear.
    next_st.status = next_st.status | ev;
    next_st.irq    = |(next_st.status & next_st.mask);
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st          <= '0;
      st.cfg.mode <= MODE_RESET;
      st.cfg.filt <= FILT_RESET;
      st.cfg.rdly <= RDLY_RESET;
      st.cfg.rcnt <= RCNT_RESET;
      st.state    <= LCF_ST_IDLE;
      st.drive    <= LCF_DRIVE_RUN;
      st.faultN   <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign wbDatOut    = st.rdata;
  assign wbAck       = st.ack;
  assign wbErr       = st.err;
  assign bridgeDrive = st.drive;
  assign fault_out_n = st.faultN;
  assign irq         = st.irq;

  sequence s_hit_idle;
    lockHit && st.state == LCF_ST_IDLE && !acc;
  endsequence

  property p_mode2;
    @(posedge clk) disable iff (!nrst)
      s_hit_idle and st.cfg.mode == LCF_MODE_LATCH_HIGH |=>
        st.drive == LCF_DRIVE_HIGH && !st.faultN && st.state == LCF_ST_LATCH;
  endproperty
  a_mode2: assert property (p_mode2) else $error("mode 2 reaction wrong");

  property p_mode3_final;
    @(posedge clk) disable iff (!nrst)
      s_hit_idle and st.cfg.mode == LCF_MODE_RETRY_TRI && st.retries >= st.cfg.rcnt |=>
        st.state == LCF_ST_LATCH && st.drive == LCF_DRIVE_TRI && !st.faultN;
  endproperty
  a_mode3_final: assert property (p_mode3_final) else $error("mode 3 no latch");

  property p_mode4;
    @(posedge clk) disable iff (!nrst)
      s_hit_idle and st.cfg.mode == LCF_MODE_RETRY_LOW |=>
        st.drive == LCF_DRIVE_LOW && !st.faultN;
  endproperty
  a_mode4: assert property (p_mode4) else $error("mode 4 not low brake");

  property p_mode5;
    @(posedge clk) disable iff (!nrst)
      s_hit_idle and st.cfg.mode == LCF_MODE_RETRY_HIGH |=>
        st.drive == LCF_DRIVE_HIGH && !st.faultN;
  endproperty
  a_mode5: assert property (p_mode5) else $error("mode 5 not high brake");

  property p_mode6;
    @(posedge clk) disable iff (!nrst)
      s_hit_idle and st.cfg.mode == LCF_MODE_REPORT |=>
        st.drive == LCF_DRIVE_RUN && !st.faultN && st.state == LCF_ST_IDLE;
  endproperty
  a_mode6: assert property (p_mode6) else $error("mode 6 acted on bridge");

  property p_mode7;
    @(posedge clk) disable iff (!nrst)
      st.cfg.mode == LCF_MODE_OFF && $stable(st.cfg.mode) |-> ##1 !lockHit;
  endproperty
  a_mode7: assert property (p_mode7) else $error("mode 7 raised lock");

  // Checked on entry only: software may lower the limit while a retry is already waiting.
  sequence s_enter_wait;
    st.state != LCF_ST_WAIT ##1 st.state == LCF_ST_WAIT;
  endsequence

  property p_retry_bound;
    @(posedge clk) disable iff (!nrst)
      s_enter_wait |-> $past(st.retries) < $past(st.cfg.rcnt) &&
                       st.retries == $past(st.retries) + 4'h1;
  endproperty
  a_retry_bound: assert property (p_retry_bound) else $error("retry count out of range");

  property p_mode1;
    @(posedge clk) disable iff (!nrst)
      s_hit_idle and st.cfg.mode == LCF_MODE_LATCH_LOW |=>
        st.drive == LCF_DRIVE_LOW && st.state == LCF_ST_LATCH && !st.faultN;
  endproperty
  a_mode1: assert property (p_mode1) else $error("mode 1 reaction wrong");

  property p_mode01;
    @(posedge clk) disable iff (!nrst)
      s_hit_idle and st.cfg.mode == LCF_MODE_LATCH_TRI |=>
        st.drive == LCF_DRIVE_TRI && st.state == LCF_ST_LATCH ##1 !st.faultN;
  endproperty
  a_mode01: assert property (p_mode01) else $error("mode 0 reaction wrong");

endmodule

// >>> common/lcf_pkg.sv
// Package with register map, field layout, timing and state types for the lock fault handler.
// How it works
// - Mode 2h latches fault, brakes high side.
// - Mode 3h retries, then latches tristated.
// - Mode 4h retries with low-side brake.
// - Mode 5h retries, then latches high brake.
// - Mode 6h only reports, bridge untouched.
// - Mode 7h disables lock detection entirely.
// - Retries counted and bounded by limit setting.
// - Filter time field bits 14-11, sixteen codes.
// - Modes 0h/1h latch, tristate or low brake.
// - Mode field bits 17-15, read-write, reset 0h.
package lcf_pkg;

  localparam int CLK_MHZ = 250;

  // Register byte offsets.
  localparam logic [3:0] OFS_CONFIG = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_MASK   = 4'h8;
  localparam logic [3:0] OFS_STATE  = 4'hC;

  // Config register fields.
  localparam int MODE_LSB   = 15;
  localparam int FILT_LSB   = 11;
  localparam int RDLY_LSB   = 0;
  localparam int RCNT_LSB   = 4;
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [3:0] FILT_RESET = 4'h0;
  localparam logic [3:0] RDLY_RESET = 4'h4;
  localparam logic [3:0] RCNT_RESET = 4'h3;

  // Status / mask bit positions.
  localparam int EV_LOCK  = 0;
  localparam int EV_LATCH = 1;
  localparam int EV_RETRY = 2;
  localparam int EV_W     = 3;

  // Lock filter times in microseconds, per code.
  localparam int FILT_US [0:15] = '{0, 100, 200, 500, 1000, 2500, 5000, 7500,
                                    10000, 25000, 50000, 75000, 100000, 200000,
                                    500000, 500000};
  // Retry delay unit in microseconds; delay is (code+1) units.
  localparam int RDLY_UNIT_US = 100000;

  typedef enum logic [2:0]
  {
    LCF_MODE_LATCH_TRI  = 3'h0,
    LCF_MODE_LATCH_LOW  = 3'h1,
    LCF_MODE_LATCH_HIGH = 3'h2,
    LCF_MODE_RETRY_TRI  = 3'h3,
    LCF_MODE_RETRY_LOW  = 3'h4,
    LCF_MODE_RETRY_HIGH = 3'h5,
    LCF_MODE_REPORT     = 3'h6,
    LCF_MODE_OFF        = 3'h7
  } lcf_mode_t;

  typedef enum logic [1:0]
  {
    LCF_DRIVE_RUN   = 2'h0,
    LCF_DRIVE_TRI   = 2'h1,
    LCF_DRIVE_LOW   = 2'h2,
    LCF_DRIVE_HIGH  = 2'h3
  } lcf_drive_t;

  // Gray coded along idle -> wait -> latched.
  typedef enum logic [1:0]
  {
    LCF_ST_IDLE  = 2'b00,
    LCF_ST_WAIT  = 2'b01,
    LCF_ST_LATCH = 2'b11
  } lcf_state_t;

  typedef struct packed
  {
    logic [31:0] adr;
    logic [31:0] dat;
    logic [3:0]  sel;
    logic        we;
    logic        cyc;
    logic        stb;
  } lcf_wb_req_t;

  typedef struct packed
  {
    logic [2:0] mode;
    logic [3:0] filt;
    logic [3:0] rdly;
    logic [3:0] rcnt;
  } lcf_cfg_t;

  function automatic lcf_drive_t lcf_brake(input logic [2:0] mode);
    unique case (mode)
      3'h1, 3'h4: lcf_brake = LCF_DRIVE_LOW;
      3'h2, 3'h5: lcf_brake = LCF_DRIVE_HIGH;
      3'h6, 3'h7: lcf_brake = LCF_DRIVE_RUN;
      default:    lcf_brake = LCF_DRIVE_TRI;
    endcase
  endfunction

endpackage

// >>> verilog/lcf_sync.sv
// Two-flop synchroniser for the over-limit comparator level.
`timescale 1ns/100ps
module lcf_sync
  import lcf_pkg::*;
(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic din,
  output logic      dout
);

  typedef struct packed
  {
    logic s1;
    logic s2;
  } lcf_sync_t;

  lcf_sync_t st;
  lcf_sync_t next_st;

  always_comb
  begin
    next_st.s1 = din;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      st <= '0;
    else
      st <= next_st;
  end

  assign dout = st.s2;

endmodule

// >>> verilog/lcf_filter.sv
// Persistence filter: the level must hold for a whole programmable time.
`timescale 1ns/100ps
module lcf_filter
  import lcf_pkg::*;
#(
  parameter int CW = 27
)
(
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire logic          level,
  input  wire logic [CW-1:0] target,
  output logic               hit
);

  typedef struct packed
  {
    logic [CW-1:0] cnt;
    logic          hit;
  } lcf_filt_t;

  lcf_filt_t st;
  lcf_filt_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.hit = 1'b0;
    if (!level)
      next_st.cnt = '0;
    else if (st.cnt >= target)
      next_st.hit = 1'b1;
    else
      next_st.cnt = st.cnt + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      st <= '0;
    else
      st <= next_st;
  end

  assign hit = st.hit;

  property p_restart;
    @(posedge clk) disable iff (!nrst) !level |=> st.cnt == '0 && !st.hit;
  endproperty
  a_restart: assert property (p_restart) else $error("filter did not restart");

endmodule

// >>> sim/lcf_bridge_model.sv
// Behavioural motor bridge that turns a locked rotor into an over-limit level.
`timescale 1ns/100ps
module lcf_bridge_model
  import lcf_pkg::*;
(
  input  wire logic       locked,
  input  wire logic [1:0] bridgeDrive,
  output logic            overLimit
);
  // Braking or tristating removes the drive current, so the comparator falls at once.
  assign overLimit = locked && (bridgeDrive == LCF_DRIVE_RUN);
endmodule

// >>> sim/test_lcf_top.sv
// Self-checking bench for the lock fault handler, driven over its register bus.
`timescale 1ns/100ps
module test_lcf_top
  import lcf_pkg::*;
;
  localparam int UNIT = 20;
  localparam logic [1:0] BRAKE [0:7] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        locked = 1'b0;
  logic        overLimit;
  logic [31:0] wbAdr = 32'h0;
  logic [31:0] wbDatIn = 32'h0;
  logic [3:0]  wbSel = 4'hF;
  logic        wbWe = 1'b0;
  logic        wbCyc = 1'b0;
  logic        wbStb = 1'b0;
  logic [31:0] wbDatOut;
  logic        wbAck;
  logic        wbErr;
  logic [1:0]  bridgeDrive;
  logic        fault_out_n;
  logic        irq;
  logic        lastErr;
  logic        prevF = 1'b1;
  logic [31:0] rd;
  int          errCount = 0;
  int          nTests = 0;
  int          rises = 0;
  int          cycles = 0;
  int          base;

  always #2 clk = ~clk;

  lcf_top #(.RDLY_UNIT_CYC(UNIT), .FILT_SCALE(1)) i_dut
  (
    .clk         (clk),
    .nrst        (nrst),
    .overLimit   (overLimit),
    .wbAdr       (wbAdr),
    .wbDatIn     (wbDatIn),
    .wbSel       (wbSel),
    .wbWe        (wbWe),
    .wbCyc       (wbCyc),
    .wbStb       (wbStb),
    .wbDatOut    (wbDatOut),
    .wbAck       (wbAck),
    .wbErr       (wbErr),
    .bridgeDrive (bridgeDrive),
    .fault_out_n (fault_out_n),
    .irq         (irq)
  );

  lcf_bridge_model i_bridge
  (
    .locked      (locked),
    .bridgeDrive (bridgeDrive),
    .overLimit   (overLimit)
  );

  task automatic giveVerdict();
    $display("Comparisons %0d, mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Rising edges of the fault pin mark each automatic clear.
  always @(posedge clk)
  begin
    prevF <= fault_out_n;
    if (fault_out_n === 1'b1 && prevF === 1'b0)
      rises <= rises + 1;
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errCount = errCount + 1;
      giveVerdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests = nTests + 1;
    if (seen !== exp)
    begin
      errCount = errCount + 1;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Entered just after a rising edge; leaves cyc low for one cycle afterwards.
  // No limit of its own: the cycle ceiling is what ends a slave that never answers.
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    wbAdr   <= {28'h0, a};
    wbWe    <= w;
    wbDatIn <= d;
    wbCyc   <= 1'b1;
    wbStb   <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (!(wbAck || wbErr));
    rd = wbDatOut;
    lastErr = wbErr;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
    @(posedge clk);
  endtask

  task automatic cfg(input logic [2:0] m, input logic [3:0] f, input logic [3:0] r,
                     input logic [3:0] d);
    wb(OFS_CONFIG, 1'b1, {14'h0, m, f, 3'h0, r, d});
  endtask

  task automatic waitFault(input int lim);
    int n;
    n = 0;
    while (fault_out_n !== 1'b0 && n < lim)
    begin
      @(posedge clk);
      n = n + 1;
    end
  endtask

  initial
  begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    wb(OFS_CONFIG, 1'b0, 32'h0);
    check(rd, 32'h0000_0034);
    wb(OFS_STATE, 1'b0, 32'h0);
    check(rd, 32'h0000_0008);
    wb(4'h2, 1'b0, 32'h0);
    check(lastErr, 1'b1);
    cfg(3'h0, 4'hE, 4'h3, 4'h4);
    wb(OFS_CONFIG, 1'b0, 32'h0);
    check(rd, 32'h0000_7034);
    // Only the low byte lane is enabled, so mode and filter code must keep their values.
    wbSel <= 4'h1;
    cfg(3'h5, 4'h9, 4'h3, 4'h4);
    wbSel <= 4'hF;
    wb(OFS_CONFIG, 1'b0, 32'h0);
    check(rd, 32'h0000_7034);
    $display("Test reset and fields done");
    wb(OFS_MASK, 1'b1, 32'h0);
    for (int m = 0; m < 3; m++)
    begin
      cfg(3'(m), 4'h0, 4'h3, 4'h4);
      locked <= 1'b1;
      waitFault(50);
      check(bridgeDrive, BRAKE[m]);
      locked <= 1'b0;
      repeat (30) @(posedge clk);
      check({bridgeDrive, fault_out_n, irq}, {BRAKE[m], 1'b0, m != 0});
      wb(OFS_MASK, 1'b1, 32'h7);
      repeat (2) @(posedge clk);
      check(irq, 1'b1);
      wb(OFS_STATUS, 1'b0, 32'h0);
      check(rd, 32'h3);
      wb(OFS_STATUS, 1'b1, 32'h7);
      repeat (2) @(posedge clk);
      check({bridgeDrive, fault_out_n, irq}, 4'b0010);
    end
    $display("Test latched modes done");
    for (int m = 3; m < 6; m++)
    begin
      cfg(3'(m), 4'h0, 4'h2, 4'h0);
      base = rises;
      locked <= 1'b1;
      waitFault(50);
      check(bridgeDrive, BRAKE[m]);
      repeat (300) @(posedge clk);
      check(rises - base, 2);
      wb(OFS_STATE, 1'b0, 32'h0);
      check(rd[7:0], {4'h2, 1'b0, BRAKE[m], 1'b1});
      wb(OFS_STATUS, 1'b0, 32'h0);
      check(rd, 32'h7);
      locked <= 1'b0;
      wb(OFS_STATUS, 1'b1, 32'h7);
      wb(OFS_STATE, 1'b0, 32'h0);
      check(rd, 32'h8);
    end
    $display("Test retry modes done");
    cfg(3'h6, 4'h0, 4'h3, 4'h4);
    locked <= 1'b1;
    waitFault(50);
    check({fault_out_n, bridgeDrive}, 3'b000);
    repeat (20) @(posedge clk);
    check(bridgeDrive, 2'h0);
    locked <= 1'b0;
    wb(OFS_STATE, 1'b0, 32'h0);
    check(rd[2:0], 3'h0);
    wb(OFS_STATUS, 1'b1, 32'h7);
    cfg(3'h7, 4'h0, 4'h3, 4'h4);
    locked <= 1'b1;
    repeat (50) @(posedge clk);
    check({fault_out_n, bridgeDrive, irq}, 4'b1000);
    wb(OFS_STATUS, 1'b0, 32'h0);
    check(rd, 32'h0);
    locked <= 1'b0;
    $display("Test report and disabled modes done");
    // A glitch shorter than the filter must leave no trace.
    cfg(3'h0, 4'h1, 4'h3, 4'h4);
    locked <= 1'b1;
    repeat (80) @(posedge clk);
    locked <= 1'b0;
    repeat (10) @(posedge clk);
    check(fault_out_n, 1'b1);
    locked <= 1'b1;
    repeat (101) @(posedge clk);
    check(fault_out_n, 1'b1);
    waitFault(3);
    check(fault_out_n, 1'b0);
    locked <= 1'b0;
    wb(OFS_STATUS, 1'b1, 32'h7);
    $display("Test filter time done");
    giveVerdict();
  end
endmodule
